/* File: bus_host_model.sv */
`timescale 1ns/1ps
module bus_host_model (
    // clock
    input  wire logic i_clk,
    // character link
    input  wire logic i_ready,
    output logic      o_valid,
    output logic [7:0] o_data,
    output logic      o_ren
);
    initial begin
        o_valid = 1'b0;
        o_data  = 8'h00;
        o_ren   = 1'b0;
    end
    // ----------------------------------------
    // host side of the character link
    // ----------------------------------------
    // value strings in the active scale
    // junction re-read well inside thirty seconds
    task automatic send(input string s);
        @(posedge i_clk);
        for (int i = 0; i < s.len(); i++) begin
            o_valid <= 1'b1;
            o_data  <= s[i];
            do @(posedge i_clk); while (i_ready !== 1'b1);
        end
        o_valid <= 1'b0;
        o_data  <= ~s[s.len()-1];
    endtask : send
    task automatic set_ren(input logic v);
        @(posedge i_clk);
        o_ren <= v;
    endtask : set_ren
endmodule : bus_host_model

/* File: cmd_buffer.sv */
`timescale 1ns/1ps
module cmd_buffer #(
    parameter int WIDTH = 8,
    parameter int ALOG  = 5
) (
    // clock
    input  wire logic             i_clk,
    // write side
    input  wire logic             i_we,
    input  wire logic [ALOG-1:0]  i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    // read side
    input  wire logic [ALOG-1:0]  i_raddr,
    output logic      [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem [2**ALOG];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule : cmd_buffer

/* File: rcc_pkg.sv */
// Summary of operation
// - function codes 5 and 6 with execute mark enter temperature mode, F or C.
// - range codes 2..8 pick thermocouple types K, J, T, E, R, R, B.
// - measure-junction command pulses a junction measurement for selected type.
// - enter-junction command takes stored value as reference and compensates.
// - filter option 0 turns smoothing off, option 1 turns it on.
// - smoothing defaults to on.
// - smoothing and digital filter are separate, independently set stages.
// - command executed while not in remote raises no-remote error.
// - unknown command letter raises illegal-command error.
// - known letter with unsupported option raises illegal-option error.
// - any bus error discards whole string and shows matching message.
// - bus error sets error and cause bits; requests service if enabled.
// - remote enable sampled only when execute mark arrives.
// - ac volts, ac amps, dc amps without fitted option give illegal option.
// - error message shown about one second, then normal display.
// - defaults restored at power-up and on device clear.
package rcc_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [4:0] ADDR_CTRL     = 5'h00;
    localparam logic [4:0] ADDR_SETTINGS = 5'h04;
    localparam logic [4:0] ADDR_STATUS   = 5'h08;
    localparam logic [4:0] ADDR_MASK     = 5'h0c;
    localparam logic [4:0] ADDR_REF      = 5'h10;
    localparam int ST_NO_REMOTE = 0;
    localparam int ST_ILL_CMD   = 1;
    localparam int ST_ILL_OPT   = 2;
    localparam int ST_DONE      = 3;
    localparam int ST_JUNCTION  = 4;
    localparam int CT_SRQ_EN    = 0;
    localparam int CT_OPT_AC    = 1;
    localparam int CT_OPT_DCA   = 2;
    // ----------------------------------------
    // characters and codes
    // ----------------------------------------
    localparam logic [7:0] CH_EXEC  = 8'h58;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_DOT   = 8'h2e;
    localparam logic [7:0] CH_0     = 8'h30;
    localparam logic [7:0] CH_9     = 8'h39;
    localparam logic [7:0] LT_F     = 8'h46;
    localparam logic [7:0] LT_R     = 8'h52;
    localparam logic [7:0] LT_N     = 8'h4e;
    localparam logic [7:0] LT_O     = 8'h4f;
    localparam logic [7:0] LT_P     = 8'h50;
    localparam logic [7:0] LT_T     = 8'h54;
    localparam logic [7:0] LT_V     = 8'h56;
    localparam logic [2:0] FN_ACV   = 3'h1;
    localparam logic [2:0] FN_ACA   = 3'h3;
    localparam logic [2:0] FN_DCA   = 3'h4;
    localparam logic [2:0] FN_FAHR  = 3'h5;
    localparam logic [2:0] FN_CELS  = 3'h6;
    localparam logic [3:0] MAX_RANGE = 4'h8;
    localparam logic [2:0] MAX_TRIG  = 3'h7;
    localparam logic [1:0] MSG_NONE = 2'h0;
    localparam logic [1:0] MSG_NREM = 2'h1;
    localparam logic [1:0] MSG_ILLEGAL_COMMAND_ERROR = 2'h2;
    localparam logic [1:0] MSG_OPT  = 2'h3;
    // ----------------------------------------
    // defaults and timing
    // ----------------------------------------
    localparam logic [2:0] RST_FUNC   = 3'h0;
    localparam logic [3:0] RST_RANGE  = 4'h0;
    localparam logic       RST_SMOOTH = 1'b1;
    localparam logic [3:0] RST_DFILT  = 4'h0;
    localparam logic [2:0] RST_TRIG   = 3'h0;
    localparam int CLK_HZ       = 40_000_000;
    localparam int MSG_TIME_MS  = 1000;
    localparam int MSG_CYCLES   = CLK_HZ / 1000 * MSG_TIME_MS;
    typedef enum logic [3:0] {
        S_IDLE   = 4'b0001,
        S_FETCH  = 4'b0010,
        S_EVAL   = 4'b0100,
        S_COMMIT = 4'b1000
    } state_type;
    typedef struct packed {
        logic [2:0]  func;
        logic [3:0]  range;
        logic        smooth;
        logic [3:0]  dfilt;
        logic [2:0]  trig;
        logic [15:0] ref_val;
    } settings_type;
    localparam settings_type SET_DEFAULT =
        '{RST_FUNC, RST_RANGE, RST_SMOOTH, RST_DFILT, RST_TRIG, 16'h0000};
endpackage : rcc_pkg

/* File: remote_command_checker.sv */
`timescale 1ns/1ps
module remote_command_checker
    import rcc_pkg::*;
#(
    parameter int ALOG       = 5,
    parameter int MSG_CYC    = MSG_CYCLES
) (
    // clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST,
    // ahb-lite slave
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic        I_HREADY,
    input  wire logic [31:0] I_HWDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    output logic [31:0]      O_HRDATA,
    // command characters
    input  wire logic        I_CHAR_VALID,
    input  wire logic [7:0]  I_CHAR_DATA,
    output logic             O_CHAR_READY,
    input  wire logic        I_DEV_CLEAR,
    input  wire logic        I_REN,
    // settings and events
    output logic             O_TEMP_MODE,
    output logic             O_FAHRENHEIT,
    output logic [2:0]       O_FUNC,
    output logic [2:0]       O_TC_TYPE,
    output logic             O_SMOOTHING_ON,
    output logic [3:0]       O_DFILT,
    output logic [2:0]       O_TRIG,
    output logic [15:0]      O_REF_TEMP,
    output logic             O_JUNCTION_MEASURE,
    output logic             O_JUNCTION_ENTER,
    // messages, service and interrupt
    output logic [1:0]       O_DISP_MSG,
    output logic             O_SRQ,
    output logic             O_IRQ
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [2:0] tc_map(input logic [3:0] r);
        case (r)
            4'h2:    tc_map = 3'h0;
            4'h3:    tc_map = 3'h1;
            4'h4:    tc_map = 3'h2;
            4'h5:    tc_map = 3'h3;
            4'h6:    tc_map = 3'h4;
            4'h7:    tc_map = 3'h4;
            4'h8:    tc_map = 3'h6;
            default: tc_map = 3'h7;
        endcase
    endfunction : tc_map

    function automatic logic known_letter(input logic [7:0] c);
        known_letter = (c == LT_F) || (c == LT_R) || (c == LT_N) || (c == LT_O)
                    || (c == LT_P) || (c == LT_T) || (c == LT_V);
    endfunction : known_letter

    function automatic logic [7:0] upcase(input logic [7:0] c);
        upcase = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
    endfunction : upcase

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        state_type    st;
        logic [ALOG:0] wp;
        logic [ALOG:0] rp;
        logic         ovf;
        logic         ren_s1;
        logic         ren_s2;
        logic         ren_x;
        logic [7:0]   letter;
        logic         have_d;
        logic         err_cmd;
        logic         err_opt;
        logic         meas_p;
        logic         enter_p;
        settings_type sh;
        settings_type cur;
        logic         meas_q;
        logic         enter_q;
        logic [2:0]   ctrl;
        logic [4:0]   status;
        logic [4:0]   mask;
        logic [1:0]   msg;
        logic [31:0]  msg_cnt;
        logic         irq;
        logic         srq;
        logic         ahb_wr;
        logic [4:0]   ahb_addr;
        logic [31:0]  hrdata;
        logic         rdy;
        logic         hready;
        logic         hresp;
        logic         temp;
        logic         fahr;
        logic [2:0]   tc;
    } core_type;

    core_type q;
    core_type d;
    logic [7:0] rd_char;
    logic [7:0] c;
    logic [3:0] dig;
    logic       opt_bad;
    logic       err_any;
    logic [4:0] set_ev;
    logic       wr_char;

    cmd_buffer #(.WIDTH(8), .ALOG(ALOG)) u_buf (
        .i_clk   (I_SYS_CLK),
        .i_we    (wr_char),
        .i_waddr (q.wp[ALOG-1:0]),
        .i_wdata (I_CHAR_DATA),
        .i_raddr (q.rp[ALOG-1:0]),
        .o_rdata (rd_char)
    );

    assign wr_char = (q.st == S_IDLE) && I_CHAR_VALID && q.rdy && !I_DEV_CLEAR
                  && (I_CHAR_DATA != CH_EXEC) && !q.wp[ALOG];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d          = q;
        c          = upcase(rd_char);
        dig        = c[3:0];
        opt_bad    = 1'b0;
        err_any    = 1'b0;
        set_ev     = 5'h00;
        d.ren_s1   = I_REN;
        d.ren_s2   = q.ren_s1;
        d.meas_q   = 1'b0;
        d.enter_q  = 1'b0;
        d.hready   = 1'b1;
        // bus side
        if (q.ahb_wr) begin
            case (q.ahb_addr)
                ADDR_CTRL: d.ctrl = I_HWDATA[2:0];
                ADDR_MASK: d.mask = I_HWDATA[4:0];
                default:   d.ctrl = d.ctrl;
            endcase
        end
        d.ahb_wr = I_HSEL && I_HREADY && I_HTRANS[1] && I_HWRITE;
        d.ahb_addr = I_HADDR[4:0];
        if (I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE) begin
            case (I_HADDR[4:0])
                ADDR_CTRL:     d.hrdata = {29'h0, q.ctrl};
                ADDR_SETTINGS: d.hrdata = {12'h0, q.cur.trig, q.cur.dfilt, q.cur.smooth,
                                           q.cur.range, q.cur.func, 3'h0, q.msg};
                ADDR_STATUS:   d.hrdata = {27'h0, q.status};
                ADDR_MASK:     d.hrdata = {27'h0, q.mask};
                ADDR_REF:      d.hrdata = {16'h0, q.cur.ref_val};
                default:       d.hrdata = 32'h0;
            endcase
        end
        // message timer
        if (q.msg_cnt != 32'h0) begin
            d.msg_cnt = q.msg_cnt - 32'h1;
        end else begin
            d.msg = MSG_NONE;
        end
        // command engine
        case (q.st)
            S_IDLE: begin
                if (I_CHAR_VALID && q.rdy) begin
                    if (I_CHAR_DATA == CH_EXEC) begin
                        d.ren_x   = q.ren_s2;
                        d.sh      = q.cur;
                        d.letter  = 8'h00;
                        d.have_d  = 1'b0;
                        d.err_cmd = q.ovf;
                        d.err_opt = 1'b0;
                        d.meas_p  = 1'b0;
                        d.enter_p = 1'b0;
                        d.rp      = '0;
                        d.rdy     = 1'b0;
                        d.st      = (q.wp == '0) ? S_COMMIT : S_FETCH;
                    end else if (q.wp[ALOG]) begin
                        d.ovf = 1'b1;
                    end else begin
                        d.wp = q.wp + 1'b1;
                    end
                end
            end
            S_FETCH: begin
                d.st = S_EVAL;
            end
            S_EVAL: begin
                d.rp = q.rp + 1'b1;
                d.st = (q.rp + 1'b1 == q.wp) ? S_COMMIT : S_FETCH;
                if (c >= CH_0 && c <= CH_9) begin
                    if (q.letter == 8'h00) begin
                        d.err_cmd = 1'b1;
                    end else if (q.letter == LT_V) begin
                        d.sh.ref_val = 16'(q.sh.ref_val * 16'd10 + {12'h0, dig});
                        d.have_d = 1'b1;
                    end else if (q.have_d) begin
                        d.err_opt = 1'b1;
                    end else begin
                        d.have_d = 1'b1;
                        case (q.letter)
                            LT_F: begin
                                opt_bad = (dig > 4'h6)
                                    || ((dig == {1'b0, FN_ACV} || dig == {1'b0, FN_ACA})
                                        && !q.ctrl[CT_OPT_AC])
                                    || (dig == {1'b0, FN_DCA} && !q.ctrl[CT_OPT_DCA]);
                                d.sh.func = dig[2:0];
                            end
                            LT_R: begin
                                opt_bad = dig > MAX_RANGE;
                                d.sh.range = dig;
                            end
                            LT_N: begin
                                opt_bad = dig > 4'h1;
                                d.sh.smooth = dig[0];
                            end
                            LT_O: begin
                                opt_bad = dig > 4'h1;
                                d.meas_p  = (dig == 4'h0) | q.meas_p;
                                d.enter_p = (dig == 4'h1) | q.enter_p;
                            end
                            LT_P: d.sh.dfilt = dig;
                            LT_T: begin
                                opt_bad = dig > {1'b0, MAX_TRIG};
                                d.sh.trig = dig[2:0];
                            end
                            default: opt_bad = 1'b0;
                        endcase
                        if (opt_bad) begin
                            d.err_opt = 1'b1;
                        end
                    end
                end else if (c == CH_SPACE || (c == CH_DOT && q.letter == LT_V)) begin
                    d.have_d = q.have_d;
                end else begin
                    if (q.letter != 8'h00 && !q.have_d) begin
                        d.err_opt = 1'b1;
                    end
                    if (!known_letter(c)) begin
                        d.err_cmd = 1'b1;
                    end
                    if (c == LT_V) begin
                        d.sh.ref_val = 16'h0000;
                    end
                    d.letter = c;
                    d.have_d = 1'b0;
                end
            end
            S_COMMIT: begin
                if (!q.ren_x) begin
                    set_ev[ST_NO_REMOTE] = 1'b1;
                    d.msg = MSG_NREM;
                end else if (q.err_cmd) begin
                    set_ev[ST_ILL_CMD] = 1'b1;
                    d.msg = MSG_ILLEGAL_COMMAND_ERROR;
                end else if (q.err_opt || (q.letter != 8'h00 && !q.have_d)) begin
                    set_ev[ST_ILL_OPT] = 1'b1;
                    d.msg = MSG_OPT;
                end else begin
                    d.cur      = q.sh;
                    d.meas_q   = q.meas_p;
                    d.enter_q  = q.enter_p;
                    set_ev[ST_DONE]     = 1'b1;
                    set_ev[ST_JUNCTION] = q.meas_p | q.enter_p;
                end
                err_any = |set_ev[ST_ILL_OPT:ST_NO_REMOTE];
                if (err_any) begin
                    d.msg_cnt = 32'(MSG_CYC);
                end
                d.wp  = '0;
                d.ovf = 1'b0;
                d.rdy = 1'b1;
                d.st  = S_IDLE;
            end
            default: d.st = S_IDLE;
        endcase
        // status, set wins over clear
        if (q.ahb_wr && q.ahb_addr == ADDR_STATUS) begin
            d.status = q.status & ~I_HWDATA[4:0];
        end
        d.status = d.status | set_ev;
        d.irq    = |(d.status & d.mask);
        d.srq    = q.ctrl[CT_SRQ_EN] && |d.status[ST_ILL_OPT:ST_NO_REMOTE];
        if (I_DEV_CLEAR) begin
            d.cur = SET_DEFAULT;
            d.wp  = '0;
            d.ovf = 1'b0;
            d.rdy = 1'b1;
            d.st  = S_IDLE;
        end
        // registered decodes of the live settings
        d.temp = (d.cur.func == FN_FAHR) || (d.cur.func == FN_CELS);
        d.fahr = d.cur.func == FN_FAHR;
        d.tc   = tc_map(d.cur.range);
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            q          <= '0;
            q.st       <= S_IDLE;
            q.cur      <= SET_DEFAULT;
            q.sh       <= SET_DEFAULT;
            q.rdy      <= 1'b1;
            q.hready   <= 1'b1;
            q.tc       <= 3'h7;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign O_HREADYOUT        = q.hready;
    assign O_HRESP            = q.hresp;
    assign O_HRDATA           = q.hrdata;
    assign O_CHAR_READY       = q.rdy;
    assign O_FUNC             = q.cur.func;
    assign O_TEMP_MODE        = q.temp;
    assign O_FAHRENHEIT       = q.fahr;
    assign O_TC_TYPE          = q.tc;
    assign O_SMOOTHING_ON     = q.cur.smooth;
    assign O_DFILT            = q.cur.dfilt;
    assign O_TRIG             = q.cur.trig;
    assign O_REF_TEMP         = q.cur.ref_val;
    assign O_JUNCTION_MEASURE = q.meas_q;
    assign O_JUNCTION_ENTER   = q.enter_q;
    assign O_DISP_MSG         = q.msg;
    assign O_SRQ              = q.srq;
    assign O_IRQ              = q.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);

    logic commit_err;
    assign commit_err = q.st == S_COMMIT
        && (!q.ren_x || q.err_cmd || q.err_opt || (q.letter != 8'h00 && !q.have_d));

    temp_entry_a: assert property ($rose(O_TEMP_MODE) |-> $past(q.st == S_COMMIT)
        || $past(I_DEV_CLEAR)) else $error("temp mode outside commit");
    tc_range_a: assert property (O_TEMP_MODE && q.cur.range == 4'h8 |-> O_TC_TYPE == 3'h6)
        else $error("type b not mapped");
    smooth_reset_a: assert property ($fell(I_RST) |-> O_SMOOTHING_ON)
        else $error("smoothing not on after reset");
    no_remote_a: assert property (q.st == S_COMMIT && !q.ren_x
        |=> q.status[ST_NO_REMOTE] && O_DISP_MSG == MSG_NREM)
        else $error("no remote error missed");
    discard_a: assert property (commit_err && !I_DEV_CLEAR |=> $stable(q.cur)
        && !O_JUNCTION_MEASURE && !O_JUNCTION_ENTER)
        else $error("faulty string executed");
    srq_err_a: assert property (commit_err && q.ctrl[CT_SRQ_EN] |=> ##1 O_SRQ)
        else $error("service request missing");
    ren_sample_a: assert property (q.st == S_IDLE && I_CHAR_VALID && q.rdy
        && I_CHAR_DATA == CH_EXEC && !I_DEV_CLEAR |=> q.ren_x == $past(q.ren_s2))
        else $error("remote not sampled at mark");
    msg_hold_a: assert property (commit_err |=> O_DISP_MSG != MSG_NONE [*8])
        else $error("message dropped early");
    clear_dflt_a: assert property (I_DEV_CLEAR |=> O_SMOOTHING_ON && O_FUNC == RST_FUNC
        && O_CHAR_READY) else $error("defaults not restored");
    busy_stall_a: assert property (q.st != S_IDLE |-> !O_CHAR_READY)
        else $error("characters taken while checking");

    ok_cmd_c: cover property (q.st == S_COMMIT && !commit_err);
    err_cmd_c: cover property (commit_err && q.err_cmd);
    junction_c: cover property (O_JUNCTION_ENTER);
    no_rem_c: cover property (q.st == S_COMMIT && !q.ren_x);
endmodule : remote_command_checker

/* File: remote_command_checker_tb_top.sv */
`timescale 1ns/1ps
module remote_command_checker_tb_top;
    import rcc_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clk, rst = 1'b1, dclr = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0, hready, valid, ready, ren;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
    logic [7:0]  data;
    logic        temp, fahr, smooth, jmeas, jent, srq, irq;
    logic [2:0]  func, tct;
    logic [3:0]  dfilt;
    logic [1:0]  msg;
    int          n_mismatch = 0, check_count = 0, n_meas = 0, n_ent = 0;
    logic [2:0]  tc_exp [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h6};
    string       opt_bad [3] = '{"T9X", "F1X", "F4X"};

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        n_meas += jmeas;
        n_ent  += jent;
    end

    remote_command_checker #(.MSG_CYC(20)) DUT (
        .I_SYS_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HREADY(hready), .I_HWDATA(hwdata),
        .O_HREADYOUT(hready), .O_HRESP(), .O_HRDATA(hrdata), .I_CHAR_VALID(valid),
        .I_CHAR_DATA(data), .O_CHAR_READY(ready), .I_DEV_CLEAR(dclr), .I_REN(ren),
        .O_TEMP_MODE(temp), .O_FAHRENHEIT(fahr), .O_FUNC(func), .O_TC_TYPE(tct),
        .O_SMOOTHING_ON(smooth), .O_DFILT(dfilt), .O_TRIG(), .O_REF_TEMP(),
        .O_JUNCTION_MEASURE(jmeas), .O_JUNCTION_ENTER(jent), .O_DISP_MSG(msg),
        .O_SRQ(srq), .O_IRQ(irq));
    bus_host_model host (.i_clk(clk), .i_ready(ready), .o_valid(valid), .o_data(data),
        .o_ren(ren));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rdat = hrdata;
        #1;
    endtask : ahb
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rdat & m, e);
    endtask : rd_chk
    task automatic run(input string s);
        host.send(s);
        repeat (2) @(posedge clk);
        while (ready !== 1'b1) @(posedge clk);
        #1;
    endtask : run
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    initial begin
        #(25 * 40000);
        n_mismatch++;
        close_out();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_chk(ADDR_SETTINGS, 32'hffffffff, 32'h1000);
        host.set_ren(1'b1);
        repeat (3) @(posedge clk);
        run("F5X"); chk({temp, fahr, func}, {2'b11, FN_FAHR});
        run("F6X"); chk({temp, fahr, func}, {2'b10, FN_CELS});
        for (int i = 2; i <= 8; i++) begin
            run($sformatf("R%0dX", i)); chk(tct, tc_exp[i-2]);
        end
        run("O0X"); chk(n_meas, 1);
        run("V25.3X");
        rd_chk(ADDR_REF, 32'hffffffff, 32'd253);
        run("O1X"); chk(n_ent, 1);
        run("P3N0X"); chk({dfilt, smooth}, 5'h06);
        run("N1X"); chk({dfilt, smooth}, 5'h07);
        ahb(1'b1, ADDR_STATUS, 32'h1f);
        ahb(1'b1, ADDR_MASK, 32'h7);
        ahb(1'b1, ADDR_CTRL, 32'h1);
        chk({srq, irq}, 2'b00);
        run("N0E1X"); chk({msg, smooth, srq, irq}, {MSG_ILLEGAL_COMMAND_ERROR, 3'b111});
        rd_chk(ADDR_STATUS, 32'h7, 32'h2);
        repeat (10) @(posedge clk); chk(msg, MSG_ILLEGAL_COMMAND_ERROR);
        repeat (10) @(posedge clk); chk(msg, MSG_NONE);
        ahb(1'b1, ADDR_STATUS, 32'h1f); chk({srq, irq}, 2'b00);
        foreach (opt_bad[i]) begin
            run(opt_bad[i]); chk(msg, MSG_OPT);
        end
        rd_chk(ADDR_STATUS, 32'h7, 32'h4);
        ahb(1'b1, ADDR_MASK, 32'h0); chk({srq, irq}, 2'b10);
        ahb(1'b1, ADDR_CTRL, 32'h6);
        run("F1X"); chk(func, FN_ACV);
        host.send("N0"); host.set_ren(1'b1);
        repeat (3) @(posedge clk);
        run("X"); chk(smooth, 1'b0);
        host.send("N1"); host.set_ren(1'b0);
        repeat (3) @(posedge clk);
        run("X"); chk({msg, smooth}, {MSG_NREM, 1'b0});
        rd_chk(ADDR_STATUS, 32'h1, 32'h1);
        rd_chk(32'h14, 32'hffffffff, 32'h0);
        @(posedge clk);
        dclr <= 1'b1;
        @(posedge clk);
        dclr <= 1'b0;
        @(posedge clk);
        #1;
        chk({smooth, dfilt, func}, {1'b1, RST_DFILT, RST_FUNC});
        close_out();
    end
endmodule : remote_command_checker_tb_top
